//--- design/dfam_top.v
// Added by the designer: the placing of the registers and the address-and-strobe port.
`include "dfam_defs.vh"

module dfam_top #(
    parameter NUM_CONTACTS = 3,
    parameter FLASH_HALF_CYC = `DFAM_FLASH_HALF_MS * (`DFAM_CLK_HZ / 1000)
) (
    // clock, reset, enable
    input wire clk,
    input wire rst_n,
    input wire ce,
    // register port
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    // detection sources
    input wire fault_det,
    input wire [7:0] fault_det_code,
    input wire minor_det,
    input wire [7:0] minor_det_code,
    input wire alarm_det,
    input wire [7:0] alarm_det_code,
    input wire oper_err_det,
    input wire [7:0] oper_err_code,
    input wire tune_active,
    input wire tune_err_det,
    input wire [7:0] tune_err_code,
    // operator side
    input wire fault_reset_pin,
    input wire run_req,
    // operator display and lamp
    output reg [7:0] display_code,
    output reg [2:0] display_class,
    output reg fault_lamp,
    // motor output
    output reg drive_run,
    output reg drive_coast,
    output reg drive_ramp_stop,
    // contact outputs
    output wire [NUM_CONTACTS-1:0] contact_out,
    // interrupt
    output wire irq
);

    localparam FLASH_W = 32;
    localparam [FLASH_W-1:0] FLASH_LAST = FLASH_HALF_CYC - 1;
    // reset request synchroniser
    reg rst_req_s1;
    reg rst_req_s2;
    reg rst_req_s3;
    wire rst_req_rise;
    // configuration
    reg [`DFAM_CTRL_W-1:0] ctrl;
    reg [7:0] sel [0:NUM_CONTACTS-1];
    // class state
    reg fault_latched;
    reg [7:0] fault_code;
    reg tune_err;
    reg [7:0] tune_code;
    reg tune_active_d;
    reg minor_d;
    reg alarm_d;
    reg oper_d;
    // flash timer
    reg [FLASH_W-1:0] flash_cnt;
    reg flash_phase;
    // interrupts
    reg [`DFAM_EV_W-1:0] int_stat;
    reg [`DFAM_EV_W-1:0] int_en;
    wire [`DFAM_EV_W-1:0] ev;
    wire [`DFAM_EV_W-1:0] int_clr;
    wire fault_rise;
    wire tune_rise;
    wire tune_start;
    wire run_ok;
    wire stop_ramp;
    wire [`DFAM_ST_W-1:0] state_word;
    reg [7:0] next_display_code;
    reg [2:0] next_display_class;
    reg next_fault_lamp;
    reg [31:0] next_rdata;
    // separate loop indices for the write and read processes
    integer k;
    integer rd_idx;
    assign rst_req_rise = rst_req_s2 & ~rst_req_s3;
    assign stop_ramp = ctrl[`DFAM_CTRL_STOP_RAMP];
    assign tune_start = tune_active & ~tune_active_d;
    assign fault_rise = fault_det & ~fault_latched;
    assign tune_rise = tune_active & tune_err_det & ~tune_err;
    // minor fault and alarm do not enter the run permission
    assign run_ok = ~fault_latched & ~oper_err_det & ~tune_err;

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_req_s1 <= 1'b0;
            rst_req_s2 <= 1'b0;
            rst_req_s3 <= 1'b0;
        end
        else if (ce)
        begin
            rst_req_s1 <= fault_reset_pin;
            rst_req_s2 <= rst_req_s1;
            rst_req_s3 <= rst_req_s2;
        end
    end
    // fault latch: reset only takes once the cause is gone
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fault_latched <= 1'b0;
            fault_code <= `DFAM_CODE_RST;
        end
        else if (ce)
        begin
            if (fault_rise)
            begin
                fault_latched <= 1'b1;
                fault_code <= fault_det_code;
            end
            else if (fault_latched && rst_req_rise && !fault_det)
            begin
                fault_latched <= 1'b0;
            end
        end
    end
    // tuning error: raised only while tuning, cleared when tuning restarts
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tune_err <= 1'b0;
            tune_code <= `DFAM_CODE_RST;
            tune_active_d <= 1'b0;
        end
        else if (ce)
        begin
            tune_active_d <= tune_active;
            if (tune_rise)
            begin
                tune_err <= 1'b1;
                tune_code <= tune_err_code;
            end
            else if (tune_start)
            begin
                tune_err <= 1'b0;
            end
        end
    end
    // lamp flash timer
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flash_cnt <= {FLASH_W{1'b0}};
            flash_phase <= 1'b0;
        end
        else if (ce)
        begin
            if (!(minor_det || alarm_det))
            begin
                flash_cnt <= {FLASH_W{1'b0}};
                flash_phase <= 1'b0;
            end
            else if (flash_cnt == FLASH_LAST)
            begin
                flash_cnt <= {FLASH_W{1'b0}};
                flash_phase <= ~flash_phase;
            end
            else
            begin
                flash_cnt <= flash_cnt + {{(FLASH_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // display priority and lamp
    always @*
    begin
        next_display_code = `DFAM_CODE_RST;
        next_display_class = `DFAM_CLS_NONE;
        next_fault_lamp = 1'b0;
        if (fault_latched)
        begin
            next_display_code = fault_code;
            next_display_class = `DFAM_CLS_FAULT;
            next_fault_lamp = 1'b1;
        end
        else if (tune_err)
        begin
            next_display_code = tune_code;
            next_display_class = `DFAM_CLS_TUNE;
        end
        else if (oper_err_det)
        begin
            next_display_code = oper_err_code;
            next_display_class = `DFAM_CLS_OPER;
        end
        else if (minor_det)
        begin
            next_display_code = minor_det_code;
            next_display_class = `DFAM_CLS_MINOR;
            next_fault_lamp = ~flash_phase;
        end
        else if (alarm_det)
        begin
            next_display_code = alarm_det_code;
            next_display_class = `DFAM_CLS_ALARM;
            next_fault_lamp = ~flash_phase;
        end
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            display_code <= `DFAM_CODE_RST;
            display_class <= `DFAM_CLS_NONE;
            fault_lamp <= 1'b0;
            drive_run <= 1'b0;
            drive_coast <= 1'b0;
            drive_ramp_stop <= 1'b0;
        end
        else if (ce)
        begin
            display_code <= next_display_code;
            display_class <= next_display_class;
            fault_lamp <= next_fault_lamp;
            drive_run <= run_req & run_ok;
            drive_coast <= (fault_latched & ~stop_ramp) | tune_err;
            drive_ramp_stop <= fault_latched & stop_ramp;
        end
    end

    // contact outputs; operation and tuning errors never reach them
    genvar g;
    generate
        for (g = 0; g < NUM_CONTACTS; g = g + 1)
        begin : g_contact
            reg closed;
            always @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    closed <= 1'b0;
                end
                else if (ce)
                begin
                    closed <= ((sel[g] == `DFAM_FN_FAULT) & fault_latched)
                        | ((sel[g] == `DFAM_FN_MINOR) & minor_det);
                end
            end
            assign contact_out[g] = closed;
        end
    endgenerate

    // interrupt events
    assign ev[`DFAM_EV_FAULT] = fault_rise;
    assign ev[`DFAM_EV_MINOR] = minor_det & ~minor_d;
    assign ev[`DFAM_EV_ALARM] = alarm_det & ~alarm_d;
    assign ev[`DFAM_EV_OPER] = oper_err_det & ~oper_d;
    assign ev[`DFAM_EV_TUNE] = tune_rise;
    assign int_clr = (reg_wr && reg_addr == `DFAM_ADDR_INT_CLR) ?
        reg_wdata[`DFAM_EV_W-1:0] : {`DFAM_EV_W{1'b0}};
    assign irq = |(int_stat & int_en);
    assign state_word = {fault_lamp, run_ok, tune_err, oper_err_det, alarm_det, minor_det,
        fault_latched};
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            minor_d <= 1'b0;
            alarm_d <= 1'b0;
            oper_d <= 1'b0;
            int_stat <= `DFAM_EV_RST;
        end
        else if (ce)
        begin
            minor_d <= minor_det;
            alarm_d <= alarm_det;
            oper_d <= oper_err_det;
            // a set in the clear cycle wins
            int_stat <= (int_stat & ~int_clr) | ev;
        end
    end

    // register writes
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl <= `DFAM_CTRL_RST;
            int_en <= `DFAM_EV_RST;
            for (k = 0; k < NUM_CONTACTS; k = k + 1)
            begin
                sel[k] <= `DFAM_SEL_RST;
            end
        end
        else if (ce && reg_wr)
        begin
            if (reg_addr == `DFAM_ADDR_CTRL)
            begin
                ctrl <= reg_wdata[`DFAM_CTRL_W-1:0];
            end
            if (reg_addr == `DFAM_ADDR_INT_EN)
            begin
                int_en <= reg_wdata[`DFAM_EV_W-1:0];
            end
            for (k = 0; k < NUM_CONTACTS; k = k + 1)
            begin
                if (reg_addr == `DFAM_ADDR_SEL_BASE + k[7:0] * `DFAM_ADDR_SEL_STEP)
                begin
                    sel[k] <= reg_wdata[7:0];
                end
            end
        end
    end

    // register reads, data one cycle later
    always @*
    begin
        next_rdata = 32'h00000000;
        case (reg_addr)
            `DFAM_ADDR_CTRL: next_rdata[`DFAM_CTRL_W-1:0] = ctrl;
            `DFAM_ADDR_STATE: next_rdata[`DFAM_ST_W-1:0] = state_word;
            `DFAM_ADDR_INT_STAT: next_rdata[`DFAM_EV_W-1:0] = int_stat;
            `DFAM_ADDR_INT_EN: next_rdata[`DFAM_EV_W-1:0] = int_en;
            `DFAM_ADDR_DISP: next_rdata[10:0] = {display_class, display_code};
            `DFAM_ADDR_FAULT_CODE: next_rdata[7:0] = fault_code;
            default: next_rdata = 32'h00000000;
        endcase
        for (rd_idx = 0; rd_idx < NUM_CONTACTS; rd_idx = rd_idx + 1)
        begin
            if (reg_addr == `DFAM_ADDR_SEL_BASE + rd_idx[7:0] * `DFAM_ADDR_SEL_STEP)
            begin
                next_rdata[7:0] = sel[rd_idx];
            end
        end
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_rdata <= 32'h00000000;
        end
        else if (ce)
        begin
            reg_rdata <= reg_rd ? next_rdata : 32'h00000000;
        end
    end

endmodule

//--- design/dfam_defs.vh
`ifndef DFAM_DEFS_VH
`define DFAM_DEFS_VH

// register byte offsets
`define DFAM_ADDR_CTRL 8'h00
`define DFAM_ADDR_STATE 8'h04
`define DFAM_ADDR_INT_STAT 8'h08
`define DFAM_ADDR_INT_EN 8'h0C
`define DFAM_ADDR_INT_CLR 8'h10
`define DFAM_ADDR_DISP 8'h14
`define DFAM_ADDR_FAULT_CODE 8'h18
`define DFAM_ADDR_SEL_BASE 8'h20
`define DFAM_ADDR_SEL_STEP 8'h04

// control register fields
`define DFAM_CTRL_STOP_RAMP 0
`define DFAM_CTRL_W 1
`define DFAM_CTRL_RST 1'h0

// state register fields
`define DFAM_ST_FAULT 0
`define DFAM_ST_MINOR 1
`define DFAM_ST_ALARM 2
`define DFAM_ST_OPER 3
`define DFAM_ST_TUNE 4
`define DFAM_ST_RUN_OK 5
`define DFAM_ST_LAMP 6
`define DFAM_ST_W 7

// event bits of status, enable and clear
`define DFAM_EV_FAULT 0
`define DFAM_EV_MINOR 1
`define DFAM_EV_ALARM 2
`define DFAM_EV_OPER 3
`define DFAM_EV_TUNE 4
`define DFAM_EV_W 5
`define DFAM_EV_RST 5'h00

// contact output function select codes
`define DFAM_FN_FAULT 8'h0E
`define DFAM_FN_MINOR 8'h10
`define DFAM_SEL_RST 8'hFF

// display class codes
`define DFAM_CLS_NONE 3'h0
`define DFAM_CLS_FAULT 3'h1
`define DFAM_CLS_TUNE 3'h2
`define DFAM_CLS_OPER 3'h3
`define DFAM_CLS_MINOR 3'h4
`define DFAM_CLS_ALARM 3'h5

// lamp flash timing and code reset value
`define DFAM_CLK_HZ 10000000
`define DFAM_FLASH_HALF_MS 500
`define DFAM_CODE_RST 8'h00

`endif

//--- verif/dfam_monitor.sv
module dfam_monitor (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // detection sources
    input wire fault_det,
    input wire minor_det,
    input wire alarm_det,
    input wire oper_err_det,
    input wire tune_active,
    input wire tune_err_det,
    // block outputs
    input wire [2:0] display_class,
    input wire fault_lamp,
    input wire drive_run,
    input wire drive_coast,
    input wire drive_ramp_stop
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking mon_cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    property p_flt_lamp;
        fault_det ##1 fault_det |-> ##1 (fault_lamp && display_class == 3'h1);
    endproperty
    a_flt_lamp: assert property (p_flt_lamp) else $error("lamp not steady on fault");
    property p_flt_stop;
        fault_det ##1 fault_det |-> ##1 (drive_coast || drive_ramp_stop);
    endproperty
    a_flt_stop: assert property (p_flt_stop) else $error("drive not stopped on fault");
    property p_flt_norun;
        fault_det ##1 fault_det |-> ##1 !drive_run;
    endproperty
    a_flt_norun: assert property (p_flt_norun) else $error("run during fault");
    property p_mnr_cls;
        display_class == 3'h4 |-> $past(minor_det);
    endproperty
    a_mnr_cls: assert property (p_mnr_cls) else $error("minor shown without cause");
    property p_alm_cls;
        display_class == 3'h5 |-> $past(alarm_det);
    endproperty
    a_alm_cls: assert property (p_alm_cls) else $error("alarm not self clearing");
    property p_oper_cls;
        display_class == 3'h3 |-> $past(oper_err_det);
    endproperty
    a_oper_cls: assert property (p_oper_cls) else $error("oper shown without cause");
    property p_oper_norun;
        oper_err_det |=> !drive_run;
    endproperty
    a_oper_norun: assert property (p_oper_norun) else $error("run during oper error");
    property p_tune_coast;
        (tune_active && $past(tune_active) && tune_err_det) ##1 tune_active |-> ##1 drive_coast;
    endproperty
    a_tune_coast: assert property (p_tune_coast) else $error("no coast on tune error");
    property p_prio;
        (fault_det && minor_det) [*3] |-> (fault_lamp && !drive_run);
    endproperty
    a_prio: assert property (p_prio) else $error("fault lost priority");
endmodule

//--- verif/dfam_panel.sv
module dfam_panel (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // bench request
    input wire press,
    // reset pin
    output logic fault_reset_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] hold;

    // button stays down four cycles
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            hold <= 3'h0;
        else if (press)
            hold <= 3'h4;
        else if (hold != 3'h0)
            hold <= hold - 3'h1;
    end
    assign fault_reset_pin = (hold != 3'h0);
endmodule

//--- verif/tb_drive_fault_alarm_manager.sv
`include "dfam_defs.vh"
module tb_drive_fault_alarm_manager;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'h0, rst_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, press = 1'h0;
    logic ce = 1'h1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic fault_det = 1'h0, minor_det = 1'h0, alarm_det = 1'h0, oper_err_det = 1'h0;
    logic tune_active = 1'h0, tune_err_det = 1'h0, run_req = 1'h0;
    logic [7:0] fcode = 8'h31, mcode = 8'h44, acode = 8'h55, ocode = 8'h66, tcode = 8'h77;
    logic [31:0] reg_rdata;
    logic [7:0] display_code;
    logic [2:0] display_class, contact_out;
    logic fault_reset_pin, fault_lamp, drive_run, drive_coast, drive_ramp_stop, irq;
    logic [17:0] outs;
    int failures = 0, tests_run = 0;

    assign outs = {display_class, display_code, fault_lamp, drive_run, drive_coast,
        drive_ramp_stop, contact_out};
    always #50 clk = ~clk;

    dfam_top #(.NUM_CONTACTS(3), .FLASH_HALF_CYC(4)) dfam_top_i (
        .clk, .rst_n, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .fault_det, .fault_det_code(fcode), .minor_det, .minor_det_code(mcode), .alarm_det,
        .alarm_det_code(acode), .oper_err_det, .oper_err_code(ocode), .tune_active,
        .tune_err_det, .tune_err_code(tcode), .fault_reset_pin, .run_req, .display_code,
        .display_class, .fault_lamp, .drive_run, .drive_coast, .drive_ramp_stop,
        .contact_out, .irq
    );
    dfam_panel dfam_panel_i (.clk, .rst_n, .press, .fault_reset_pin);

    task automatic stop_test;
        if (failures == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            failures++;
            $display("MISMATCH %s exp %0h got %0h", n, e, g);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge clk);
        reg_wr <= 1'h0;
    endtask
    task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge clk);
        reg_rd <= 1'h0;
        #1;
        chk(n, e, reg_rdata);
    endtask
    task automatic push;
        @(posedge clk);
        press <= 1'h1;
        @(posedge clk);
        press <= 1'h0;
    endtask

    task automatic s_regs;
        rdc("sel0", `DFAM_ADDR_SEL_BASE, 32'hFF);
        rdc("none", 8'hFC, 32'h0);
        wr(`DFAM_ADDR_SEL_BASE, 32'h0E);
        wr(8'h24, 32'h10);
        wr(8'h28, 32'h33);
        rdc("sel1", 8'h24, 32'h10);
        @(posedge clk);
        run_req <= 1'h1;
        wt(2);
        chk("idle", 7'h20, outs[6:0]);
    endtask
    task automatic s_fault;
        @(posedge clk);
        fault_det <= 1'h1;
        wt(2);
        chk("flt", {3'h1, 8'h31, 4'hA, 3'h1}, outs);
        @(posedge clk);
        fault_det <= 1'h0;
        wt(4);
        chk("hold", {3'h1, 8'h31, 4'hA, 3'h1}, outs);
        rdc("fcode", `DFAM_ADDR_FAULT_CODE, 32'h31);
        push;
        wt(8);
        chk("rst", 7'h20, outs[6:0]);
        wr(`DFAM_ADDR_CTRL, 32'h1);
        @(posedge clk);
        fcode <= 8'hC3;
        fault_det <= 1'h1;
        push;
        wt(8);
        chk("ramp", {3'h1, 8'hC3, 4'h9, 3'h1}, outs);
        @(posedge clk);
        fault_det <= 1'h0;
        push;
        wt(8);
        chk("rst2", 7'h20, outs[6:0]);
        wr(`DFAM_ADDR_CTRL, 32'h0);
    endtask
    task automatic s_minor;
        wr(`DFAM_ADDR_INT_EN, 32'h2);
        @(posedge clk);
        minor_det <= 1'h1;
        wt(2);
        chk("mnr", {3'h4, 8'h44, 4'hC, 3'h2}, outs);
        chk("irq", 1'h1, irq);
        wt(6);
        chk("flash", 1'h0, fault_lamp);
        @(posedge clk);
        minor_det <= 1'h0;
        alarm_det <= 1'h1;
        wt(2);
        chk("alm", {3'h5, 8'h55}, outs[17:7]);
        chk("almc", 6'h20, outs[5:0]);
        @(posedge clk);
        alarm_det <= 1'h0;
        wt(2);
        chk("auto", 4'h0, {display_class, fault_lamp});
        wr(`DFAM_ADDR_INT_EN, 32'h0);
        wt(1);
        chk("mask", 1'h0, irq);
        rdc("stat", `DFAM_ADDR_INT_STAT, 32'h7);
        wr(`DFAM_ADDR_INT_CLR, 32'h1F);
        wr(`DFAM_ADDR_INT_EN, 32'h6);
        wt(1);
        chk("clr", 1'h0, irq);
    endtask
    task automatic s_oper;
        @(posedge clk);
        oper_err_det <= 1'h1;
        wt(2);
        chk("oper", {3'h3, 8'h66}, outs[17:7]);
        chk("operc", 6'h00, outs[5:0]);
        @(posedge clk);
        oper_err_det <= 1'h0;
        wt(2);
        chk("operx", 6'h20, outs[5:0]);
    endtask
    task automatic s_tune;
        @(posedge clk);
        tune_err_det <= 1'h1;
        wt(2);
        chk("notune", 3'h0, display_class);
        @(posedge clk);
        tune_err_det <= 1'h0;
        tune_active <= 1'h1;
        @(posedge clk);
        tune_err_det <= 1'h1;
        @(posedge clk);
        tune_err_det <= 1'h0;
        wt(1);
        chk("tune", {3'h2, 8'h77}, outs[17:7]);
        chk("tunec", 6'h10, outs[5:0]);
        @(posedge clk);
        tune_active <= 1'h0;
        wt(3);
        chk("tuneh", 6'h10, outs[5:0]);
        @(posedge clk);
        tune_active <= 1'h1;
        wt(3);
        chk("tunex", 6'h20, outs[5:0]);
        @(posedge clk);
        tune_active <= 1'h0;
    endtask
    task automatic s_prio;
        @(posedge clk);
        fault_det <= 1'h1;
        minor_det <= 1'h1;
        wt(2);
        repeat (6)
        begin
            chk("prio", 5'h06, {display_class, fault_lamp, drive_run});
            wt(1);
        end
        @(posedge clk);
        fault_det <= 1'h0;
        minor_det <= 1'h0;
        push;
        wt(8);
        chk("rst3", 7'h20, outs[6:0]);
    endtask
    task automatic s_ce;
        @(posedge clk);
        ce <= 1'h0;
        minor_det <= 1'h1;
        wt(3);
        chk("frz", 4'h0, {display_class, contact_out[1]});
        @(posedge clk);
        ce <= 1'h1;
        wt(2);
        chk("thaw", 4'h9, {display_class, contact_out[1]});
        @(posedge clk);
        minor_det <= 1'h0;
        wt(2);
        chk("thawx", 4'h0, {display_class, contact_out[1]});
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        failures++;
        stop_test;
    end
    initial
    begin
        repeat (16) @(posedge clk);
        rst_n <= 1'h1;
        s_regs;
        s_fault;
        s_minor;
        s_oper;
        s_tune;
        s_prio;
        s_ce;
        stop_test;
    end
endmodule
bind dfam_top dfam_monitor dfam_monitor_i (.clk, .rst_n, .fault_det, .minor_det, .alarm_det,
    .oper_err_det, .tune_active, .tune_err_det, .display_class, .fault_lamp, .drive_run,
    .drive_coast, .drive_ramp_stop);
